// file: adcs_consts.vh
// constants for the converter sequencer: register map, fields, reset values and timing
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH

`define ADCS_ADDR_CTRL0    12'h000
`define ADCS_ADDR_CTRL1    12'h004
`define ADCS_ADDR_TRIG     12'h008
`define ADCS_ADDR_RES_HI   12'h00C
`define ADCS_ADDR_RES_LO   12'h010
`define ADCS_ADDR_STATUS   12'h014

`define ADCS_CTRL0_RESET   8'h00
`define ADCS_CTRL1_RESET   8'h00
`define ADCS_TRIG_RESET    8'h00

`define ADCS_BIT_ENABLE    0
`define ADCS_BIT_BUSY      1
`define ADCS_BIT_FORMAT    7
`define ADCS_BIT_DONE      0
`define ADCS_BIT_IRQ_EN    1

// trigger select codes
`define ADCS_TRG_NONE      4'h0
`define ADCS_TRG_PWM1_IRQ  4'h1
`define ADCS_TRG_PWM2_IRQ  4'h2
`define ADCS_TRG_T0_WRAP   4'h3
`define ADCS_TRG_T1_WRAP   4'h4
`define ADCS_TRG_T2_HIT    4'h5
`define ADCS_TRG_CMP1      4'h6
`define ADCS_TRG_PWM3_IRQ  4'h7
`define ADCS_TRG_PWM1_OFS  4'h8
`define ADCS_TRG_PWM2_OFS  4'h9
`define ADCS_TRG_PWM3_OFS  4'hA

// channel and reference codes
`define ADCS_CHS_LAST_PIN  5'h03
`define ADCS_CHS_TEMP      5'h1D
`define ADCS_CHS_DAC       5'h1E
`define ADCS_CHS_FVR       5'h1F
`define ADCS_REF_RSVD      2'h1

// a conversion is 23 half conversion-clock periods (11.5 periods)
`define ADCS_HALF_TICKS    5'd23
`define ADCS_SETUP_HALVES  5'd3

`endif

// file: adcs_conversion_sequencer_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`include "adcs_consts.vh"
module adcs_conversion_sequencer_tb;
  logic        clk_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0, sleep = 0, err, fmt;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [18:0] src = 0;
  logic [9:0]  level = 10'h2A5;
  logic [15:0] ex;
  int          n_fail = 0, check_count = 0, t0_seen = 0, t1_seen = 0, c, i;
  int          map [0:11] = '{0, 8, 12, 0, 1, 2, 3, 16, 4, 5, 6, 0};
  int          half [0:2] = '{1, 2, 4};
  logic [2:0]  code [0:2] = '{3'h0, 3'h4, 3'h1};
  wire         pready, pslverr, busy, power, wake, t0f, t1f, conn, cmp, rc, refok;
  wire [31:0]  prdata;
  wire [9:0]   trial;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) if (t0f === 1'b1) t0_seen++;
  always @(posedge clk_in) if (t1f === 1'b1) t1_seen++;
  adcs_sequencer adcs_sequencer_inst (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr),
    .prdata_out(prdata), .sleep_in(sleep), .rc_tick_in(rc), .wake_request_out(wake), .timer0_wrap_in(src[0]),
    .timer1_wrap_in(src[1]), .timer2_period_hit_in(src[2]), .comparator1_synced_output_in(src[3]),
    .pwm_offset_match_in(src[6:4]), .pwm_match_in(src[18:7]), .pwm_irq_enable_register_in(12'h222),
    .timer0_flag_set_out(t0f), .timer1_flag_set_out(t1f), .sar_compare_in(cmp), .converter_power_out(power),
    .sample_out(), .sar_trial_out(trial), .channel_code_out(), .channel_connected_out(conn),
    .positive_reference_out(), .reference_valid_out(refok), .result_out(), .busy_out(busy));
  adcs_far_model adcs_far_model_inst (.clk_in(clk_in), .power_in(power), .trial_in(trial), .level_in(level),
    .compare_out(cmp), .rc_tick_out(rc));
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk_in);
    penable <= 1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) n_fail++;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(what, rd, exp);
  endtask
  task wait_done(output int n);
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask
  task pulse(input int k);
    @(posedge clk_in);
    src[k] <= 1;
    repeat (2) @(posedge clk_in);
    src[k] <= 0;
    #1;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 0;
    rdc("control0", `ADCS_ADDR_CTRL0, 0);
    rdc("control1", `ADCS_ADDR_CTRL1, 0);
    rdc("trigger", `ADCS_ADDR_TRIG, 0);
    rdc("unmapped", 12'h020, 0);
    chk("unmapped error", err, 1);
    wr(`ADCS_ADDR_CTRL0, 2);
    rdc("start while off", `ADCS_ADDR_CTRL0, 0);
    for (i = 0; i < 32; i++) begin
      wr(`ADCS_ADDR_CTRL0, i << 2);
      chk("channel connected", conn, i <= 3 || i >= 29);
    end
    for (i = 0; i < 4; i++) begin
      wr(`ADCS_ADDR_CTRL1, 32'h0000_000C | i);
      chk("reference valid", refok, i != 1);
      rdc("control1 unused bits", `ADCS_ADDR_CTRL1, i);
    end
    $display("test registers done");
    wr(`ADCS_ADDR_CTRL0, 1); // enable alone, start in a later write
    repeat (4) @(posedge clk_in); // acquisition wait before start
    for (i = 0; i < 3; i++) begin
      fmt = (i != 1);
      level = 10'h155 << i;
      ex = fmt ? {6'h00, level} : {level, 6'h00};
      wr(`ADCS_ADDR_CTRL1, {24'h0, fmt, code[i], 4'h0});
      wr(`ADCS_ADDR_CTRL0, 3);
      wait_done(c);
      chk("conversion length", c, 23 * half[i] + 1);
      rdc("result high", `ADCS_ADDR_RES_HI, ex[15:8]);
      rdc("result low", `ADCS_ADDR_RES_LO, ex[7:0]);
      rdc("done flag", `ADCS_ADDR_STATUS, 1);
      rdc("busy cleared", `ADCS_ADDR_CTRL0, 1);
      wr(`ADCS_ADDR_STATUS, 1);
    end
    rdc("flag cleared", `ADCS_ADDR_STATUS, 0);
    level = 10'h2A5;
    wr(`ADCS_ADDR_CTRL1, 32'hE0);
    wr(`ADCS_ADDR_CTRL0, 3);
    repeat (180) @(posedge clk_in); // abort lands after the first bit decision, before the second
    wr(`ADCS_ADDR_CTRL0, 1);
    rdc("abort busy", `ADCS_ADDR_CTRL0, 1);
    rdc("partial high", `ADCS_ADDR_RES_HI, 3);
    rdc("partial low", `ADCS_ADDR_RES_LO, 32'hFF);
    $display("test conversions done");
    wr(`ADCS_ADDR_CTRL1, 32'h80);
    for (i = 1; i < 12; i++) begin
      wr(`ADCS_ADDR_TRIG, i << 4);
      pulse(map[i]); // sources stay low between trigger
      chk("trigger start", busy, i < 11);
      wait_done(c);
    end
    wr(`ADCS_ADDR_TRIG, 32'h10);
    pulse(7);
    chk("disabled match", busy, 0);
    chk("timer0 flag", t0_seen, 1);
    chk("timer1 flag", t1_seen, 1);
    $display("test triggers done");
    wr(`ADCS_ADDR_CTRL1, 32'hE0);
    wr(`ADCS_ADDR_CTRL0, 3);
    @(posedge clk_in);
    sleep <= 1;
    repeat (2) @(posedge clk_in);
    #1;
    chk("sleep abort", busy, 0);
    chk("sleep power", power, 0);
    rdc("enable kept", `ADCS_ADDR_CTRL0, 1);
    @(posedge clk_in);
    sleep <= 0;
    wr(`ADCS_ADDR_STATUS, 3);
    wr(`ADCS_ADDR_CTRL1, 32'h30);
    wr(`ADCS_ADDR_CTRL0, 3);
    @(posedge clk_in);
    sleep <= 1;
    wait_done(c);
    chk("wake request", wake, 1);
    chk("power kept", power, 1);
    wr(`ADCS_ADDR_STATUS, 1);
    wr(`ADCS_ADDR_CTRL0, 3);
    wait_done(c);
    chk("no wake", wake, 0);
    chk("powered down", power, 0);
    rdc("enable stays", `ADCS_ADDR_CTRL0, 1);
    @(posedge clk_in);
    sleep <= 0;
    $display("test sleep done");
    wr(`ADCS_ADDR_CTRL0, 3);
    @(posedge clk_in);
    reset_in <= 1;
    @(posedge clk_in);
    reset_in <= 0;
    rdc("reset mid run", `ADCS_ADDR_CTRL0, 0);
    rdc("reset result", `ADCS_ADDR_RES_HI, 0);
    chk("reset power", power, 0);
    $display("test reset done");
    complete_run;
  end
endmodule

// file: adcs_far_model.sv
// behavioural analog front end and internal rc oscillator facing the sequencer
`timescale 1ns/10ps
module adcs_far_model (
  // clock
  input  wire logic       clk_in,
  // sequencer side
  input  wire logic       power_in,
  input  wire logic [9:0] trial_in,
  input  wire logic [9:0] level_in,
  output logic            compare_out,
  output logic            rc_tick_out
);
  logic [1:0] div_r  = 2'h0;
  logic       last_r = 1'b0;
  // unpowered comparator shows the inverse of its last answer, so a stale value never looks valid
  assign compare_out = power_in ? (level_in >= trial_in) : ~last_r;
  // the rc oscillator runs free, one half period every four system cycles
  assign rc_tick_out = (div_r == 2'h3);
  always @(posedge clk_in) begin
    last_r <= compare_out;
    div_r  <= div_r + 2'h1;
  end
endmodule

// file: adcs_sequencer.v
// converter sequencer: APB registers, start/abort control, SAR stepping, triggers
`timescale 1ns/10ps
`include "adcs_consts.vh"
module adcs_sequencer (
  // clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output wire        pslverr_out,
  output reg  [31:0] prdata_out,
  // power state and internal RC conversion clock
  input  wire        sleep_in,
  input  wire        rc_tick_in,
  output wire        wake_request_out,
  // trigger sources
  input  wire        timer0_wrap_in,
  input  wire        timer1_wrap_in,
  input  wire        timer2_period_hit_in,
  input  wire        comparator1_synced_output_in,
  input  wire [2:0]  pwm_offset_match_in,
  input  wire [11:0] pwm_match_in,
  input  wire [11:0] pwm_irq_enable_register_in,
  output reg         timer0_flag_set_out,
  output reg         timer1_flag_set_out,
  // analog front end
  input  wire        sar_compare_in,
  output wire        converter_power_out,
  output reg         sample_out,
  output reg  [9:0]  sar_trial_out,
  output reg  [4:0]  channel_code_out,
  output reg         channel_connected_out,
  output reg  [1:0]  positive_reference_out,
  output reg         reference_valid_out,
  // conversion result, raw
  output reg  [9:0]  result_out,
  output wire        busy_out
);
  reg  [7:0] ctrl0_r;
  reg  [7:0] ctrl1_r;
  reg  [7:0] trig_r;
  reg  [7:0] result_high_byte_r;
  reg  [7:0] result_low_byte_r;
  reg        conversion_done_flag_r;
  reg        conversion_done_irq_enable_r;
  reg        powered_down_r;
  reg        sleep_prev_r;
  reg  [4:0] half_cnt_r;
  reg  [9:0] sar_r;
  reg  [3:0] bit_idx_r;
  reg        any_bit_r;
  reg        last_bit_r;
  reg  [10:0] src_prev_r;
  wire       half_tick;

  wire converter_enable = ctrl0_r[`ADCS_BIT_ENABLE];
  wire busy             = ctrl0_r[`ADCS_BIT_BUSY];
  wire result_format    = ctrl1_r[`ADCS_BIT_FORMAT];
  wire [2:0] conv_clk   = ctrl1_r[6:4];
  wire rc_selected      = (conv_clk[1:0] == 2'b11);
  wire [3:0] trg_sel    = trig_r[7:4];

  assign busy_out            = busy;
  assign converter_power_out = converter_enable & ~powered_down_r;
  assign wake_request_out    = sleep_in & conversion_done_flag_r & conversion_done_irq_enable_r;

  // register map, one byte-wide register per aligned word:
  //   0x00 control 0: [6:2] channel, [1] busy, [0] enable
  //   0x04 control 1: [7] format, [6:4] clock, [1:0] reference
  //   0x08 trigger:   [7:4] select
  //   0x0c result high, 0x10 result low (read only, writes ignored)
  //   0x14 status:    [1] done irq enable, [0] done flag (write 1 clears)
  // unmapped addresses answer with pslverr and read zero
  localparam [2:0] SLOT_CTRL0  = 3'd0;
  localparam [2:0] SLOT_CTRL1  = 3'd1;
  localparam [2:0] SLOT_TRIG   = 3'd2;
  localparam [2:0] SLOT_RES_HI = 3'd3;
  localparam [2:0] SLOT_RES_LO = 3'd4;
  localparam [2:0] SLOT_STATUS = 3'd5;
  localparam [2:0] SLOT_NONE   = 3'd7;

  // one decode shared by the write strobes, the error answer and the read mux
  function [2:0] reg_slot;
    input [11:0] a;
    begin
      if (a == `ADCS_ADDR_CTRL0)
        reg_slot = SLOT_CTRL0;
      else if (a == `ADCS_ADDR_CTRL1)
        reg_slot = SLOT_CTRL1;
      else if (a == `ADCS_ADDR_TRIG)
        reg_slot = SLOT_TRIG;
      else if (a == `ADCS_ADDR_RES_HI)
        reg_slot = SLOT_RES_HI;
      else if (a == `ADCS_ADDR_RES_LO)
        reg_slot = SLOT_RES_LO;
      else if (a == `ADCS_ADDR_STATUS)
        reg_slot = SLOT_STATUS;
      else
        reg_slot = SLOT_NONE;
    end
  endfunction

  // APB: zero wait states, read data captured in the setup cycle
  wire [2:0] slot = reg_slot(paddr_in);
  wire setup    = psel_in & ~penable_in;
  wire access   = psel_in & penable_in;
  wire wr       = access & pwrite_in;
  wire mapped   = (slot != SLOT_NONE);
  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~mapped;

  wire wr_ctrl0  = wr && (slot == SLOT_CTRL0);
  wire wr_ctrl1  = wr && (slot == SLOT_CTRL1);
  wire wr_trig   = wr && (slot == SLOT_TRIG);
  wire wr_status = wr && (slot == SLOT_STATUS);

  // trigger sources in select-code order, index = code - 1
  wire [2:0] pwm_irq_any;
  assign pwm_irq_any[0] = |(pwm_match_in[3:0] & pwm_irq_enable_register_in[3:0]);
  assign pwm_irq_any[1] = |(pwm_match_in[7:4] & pwm_irq_enable_register_in[7:4]);
  assign pwm_irq_any[2] = |(pwm_match_in[11:8] & pwm_irq_enable_register_in[11:8]);
  wire [10:0] src = {pwm_offset_match_in, pwm_irq_any[2], comparator1_synced_output_in,
                     timer2_period_hit_in, timer1_wrap_in, timer0_wrap_in,
                     pwm_irq_any[1], pwm_irq_any[0]};
  wire [10:0] src_rise = src & ~src_prev_r;

  function trig_pick;
    input [3:0]  sel;
    input [10:0] rise;
    begin
      if (sel == `ADCS_TRG_NONE || sel > `ADCS_TRG_PWM3_OFS)
        trig_pick = 1'b0;
      else
        trig_pick = rise[sel - 4'd1];
    end
  endfunction

  wire trigger_hit = trig_pick(trg_sel, src_rise);

  // fill bits not yet decided with the last decided bit
  function [9:0] fill_partial;
    input [9:0] code;
    input [3:0] idx;
    input       seen;
    input       last;
    integer i;
    begin
      fill_partial = code;
      for (i = 0; i < 10; i = i + 1) begin
        if (!seen || i <= idx)
          fill_partial[i] = seen ? last : 1'b0;
      end
    end
  endfunction

  // justification applied as the result is loaded
  function [15:0] justify;
    input [9:0] r;
    input       right;
    begin
      if (right)
        justify = {6'b00_0000, r};
      else
        justify = {r, 6'b00_0000};
    end
  endfunction

  wire sleep_entry = sleep_in & ~sleep_prev_r;
  wire sw_start    = wr_ctrl0 & pwdata_in[`ADCS_BIT_BUSY] & pwdata_in[`ADCS_BIT_ENABLE];
  wire can_start   = converter_enable & ~powered_down_r & ~(sleep_in & ~rc_selected);
  wire hw_start    = trigger_hit & can_start & ~busy;
  wire sw_abort    = busy & wr_ctrl0 & ~pwdata_in[`ADCS_BIT_BUSY];
  wire off_abort   = busy & wr_ctrl0 & ~pwdata_in[`ADCS_BIT_ENABLE];
  wire sleep_abort = busy & sleep_entry & ~rc_selected;
  // the half tick is registered, so busy spans 23 half periods plus one system cycle
  wire bit_step    = busy & half_tick & (half_cnt_r >= `ADCS_SETUP_HALVES) & ~half_cnt_r[0];
  wire finish      = busy & half_tick & (half_cnt_r == `ADCS_HALF_TICKS - 5'd1);
  wire [9:0] final_code = bit_step ? (sar_r | ({9'd0, sar_compare_in} << bit_idx_r)) : sar_r;

  adcs_tick_gen adcs_tick_gen_inst (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .run_in        (busy),
    .clk_field_in  (conv_clk),
    .rc_tick_in    (rc_tick_in),
    .half_tick_out (half_tick)
  );

  always @(posedge clk_in) begin
    if (reset_in) begin
      ctrl0_r                      <= `ADCS_CTRL0_RESET;
      ctrl1_r                      <= `ADCS_CTRL1_RESET;
      trig_r                       <= `ADCS_TRIG_RESET;
      result_high_byte_r           <= 8'h00;
      result_low_byte_r            <= 8'h00;
      result_out                   <= 10'h000;
      conversion_done_flag_r       <= 1'b0;
      conversion_done_irq_enable_r <= 1'b0;
      powered_down_r               <= 1'b0;
      sleep_prev_r                 <= 1'b0;
      half_cnt_r                   <= 5'd0;
      sar_r                        <= 10'h000;
      bit_idx_r                    <= 4'd9;
      any_bit_r                    <= 1'b0;
      last_bit_r                   <= 1'b0;
      src_prev_r                   <= 11'h000;
      timer0_flag_set_out          <= 1'b0;
      timer1_flag_set_out          <= 1'b0;
      prdata_out                   <= 32'h0000_0000;
    end else begin
      sleep_prev_r <= sleep_in;
      src_prev_r   <= src;
      timer0_flag_set_out <= (trg_sel == `ADCS_TRG_T0_WRAP) & src_rise[2];
      timer1_flag_set_out <= (trg_sel == `ADCS_TRG_T1_WRAP) & src_rise[3];

      if (wr_ctrl1)
        ctrl1_r <= {pwdata_in[7:4], 2'b00, pwdata_in[1:0]};
      if (wr_trig)
        trig_r <= {pwdata_in[7:4], 4'h0};
      if (wr_status)
        conversion_done_irq_enable_r <= pwdata_in[`ADCS_BIT_IRQ_EN];

      // power-down while asleep; released on wake
      if (!sleep_in)
        powered_down_r <= 1'b0;
      else if (sleep_abort || (sleep_entry && !rc_selected && converter_enable))
        powered_down_r <= 1'b1;
      else if (finish && !conversion_done_irq_enable_r)
        powered_down_r <= 1'b1;

      // control register 0 and the busy bit
      if (wr_ctrl0) begin
        ctrl0_r[7]   <= 1'b0;
        ctrl0_r[6:2] <= pwdata_in[6:2];
        ctrl0_r[`ADCS_BIT_ENABLE] <= pwdata_in[`ADCS_BIT_ENABLE];
      end
      if (finish || sw_abort || off_abort || sleep_abort)
        ctrl0_r[`ADCS_BIT_BUSY] <= 1'b0;
      else if ((sw_start && !busy && can_start) || hw_start)
        ctrl0_r[`ADCS_BIT_BUSY] <= 1'b1;

      // successive approximation stepping
      if (!busy) begin
        half_cnt_r <= 5'd0;
        sar_r      <= 10'h000;
        bit_idx_r  <= 4'd9;
        any_bit_r  <= 1'b0;
        last_bit_r <= 1'b0;
      end else if (half_tick) begin
        half_cnt_r <= half_cnt_r + 5'd1;
        if (bit_step) begin
          sar_r      <= final_code;
          last_bit_r <= sar_compare_in;
          any_bit_r  <= 1'b1;
          if (bit_idx_r != 4'd0)
            bit_idx_r <= bit_idx_r - 4'd1;
        end
      end

      // result load on completion or on a software abort that keeps enable set
      if (finish) begin
        result_out <= final_code;
        {result_high_byte_r, result_low_byte_r} <= justify(final_code, result_format);
      end else if (sw_abort && !off_abort) begin
        result_out <= fill_partial(sar_r, bit_idx_r, any_bit_r, last_bit_r);
        {result_high_byte_r, result_low_byte_r} <=
          justify(fill_partial(sar_r, bit_idx_r, any_bit_r, last_bit_r), result_format);
      end

      // done flag: set beats a simultaneous clear
      if (finish)
        conversion_done_flag_r <= 1'b1;
      else if (wr_status && pwdata_in[`ADCS_BIT_DONE])
        conversion_done_flag_r <= 1'b0;

      if (setup) begin
        if (slot == SLOT_CTRL0)
          prdata_out <= {24'h00_0000, ctrl0_r};
        else if (slot == SLOT_CTRL1)
          prdata_out <= {24'h00_0000, ctrl1_r};
        else if (slot == SLOT_TRIG)
          prdata_out <= {24'h00_0000, trig_r};
        else if (slot == SLOT_RES_HI)
          prdata_out <= {24'h00_0000, result_high_byte_r};
        else if (slot == SLOT_RES_LO)
          prdata_out <= {24'h00_0000, result_low_byte_r};
        else if (slot == SLOT_STATUS)
          prdata_out <= {24'h00_0000, 6'b00_0000, conversion_done_irq_enable_r, conversion_done_flag_r};
        else
          prdata_out <= 32'h0000_0000;
      end
    end
  end

  // analog-side decode; trial code holds the next bit under test
  always @* begin
    sample_out    = converter_power_out & ~busy;
    sar_trial_out = busy ? (sar_r | ({9'd0, 1'b1} << bit_idx_r)) : 10'h000;
    channel_code_out      = ctrl0_r[6:2];
    channel_connected_out = (ctrl0_r[6:2] <= `ADCS_CHS_LAST_PIN) ||
                            (ctrl0_r[6:2] >= `ADCS_CHS_TEMP);
    positive_reference_out = ctrl1_r[1:0];
    reference_valid_out    = (ctrl1_r[1:0] != `ADCS_REF_RSVD);
  end
endmodule

// file: adcs_sequencer_asserts.sv
// port assertions for the converter sequencer
`timescale 1ns/10ps
`include "adcs_consts.vh"
module adcs_sequencer_asserts (
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [31:0] prdata_out,
  input wire logic        sleep_in,
  input wire logic        wake_request_out,
  input wire logic        timer0_wrap_in,
  input wire logic        timer0_flag_set_out,
  input wire logic        converter_power_out,
  input wire logic [4:0]  channel_code_out,
  input wire logic        channel_connected_out,
  input wire logic [9:0]  result_out,
  input wire logic        busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire acc = psel_in && penable_in;
  wire wr0 = acc && pwrite_in && paddr_in == `ADCS_ADDR_CTRL0;
  sequence s_start;
    wr0 && pwdata_in[1:0] == 2'h3 && converter_power_out && !busy_out && !sleep_in;
  endsequence
  sequence s_t0_pulse;
    $past(timer0_wrap_in) ##1 !timer0_flag_set_out;
  endsequence
  property p_ready; acc |-> pready_out; endproperty
  property p_unmapped;
    acc && paddr_in > `ADCS_ADDR_STATUS |-> pslverr_out && (pwrite_in || prdata_out == 32'h0000_0000);
  endproperty
  property p_start; s_start |=> busy_out; endproperty
  property p_refuse; wr0 && !pwdata_in[0] && !busy_out |=> !busy_out [*2]; endproperty
  property p_power; wr0 && !pwdata_in[0] |=> !converter_power_out; endproperty
  property p_load; $changed(result_out) && !$past(reset_in) |-> $fell(busy_out); endproperty
  property p_rdbusy; acc && !pwrite_in && paddr_in == `ADCS_ADDR_CTRL0 |-> prdata_out[1] == $past(busy_out); endproperty
  property p_t0; timer0_flag_set_out |-> s_t0_pulse; endproperty
  property p_wake; wake_request_out |-> sleep_in; endproperty
  property p_chan;
    channel_connected_out == (channel_code_out <= `ADCS_CHS_LAST_PIN || channel_code_out >= `ADCS_CHS_TEMP);
  endproperty
  property p_reset; $fell(reset_in) |-> !busy_out && !converter_power_out && result_out == 10'h000; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_start: assert property (p_start) else $error("start write did not set busy");
  a_refuse: assert property (p_refuse) else $error("start while disabled took effect");
  a_power: assert property (p_power) else $error("converter powered while disabled");
  a_load: assert property (p_load) else $error("result changed outside a busy fall");
  a_rdbusy: assert property (p_rdbusy) else $error("busy read back wrong");
  a_t0: assert property (p_t0) else $error("timer0 flag pulse without wrap");
  a_wake: assert property (p_wake) else $error("wake request while awake");
  a_chan: assert property (p_chan) else $error("channel decode wrong");
  a_reset: assert property (p_reset) else $error("state not cleared by reset");
endmodule
bind adcs_sequencer adcs_sequencer_asserts adcs_sequencer_asserts_inst (.clk_in, .reset_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .sleep_in, .wake_request_out,
  .timer0_wrap_in, .timer0_flag_set_out, .converter_power_out, .channel_code_out, .channel_connected_out,
  .result_out, .busy_out);

// file: adcs_tick_gen.v
// half-period tick generator for the conversion clock
`timescale 1ns/10ps
`include "adcs_consts.vh"
module adcs_tick_gen (
  // clock and reset
  input  wire       clk_in,
  input  wire       reset_in,
  // control
  input  wire       run_in,
  input  wire [2:0] clk_field_in,
  input  wire       rc_tick_in,
  // tick
  output reg        half_tick_out
);
  reg [5:0] cnt_r;

  // system clock cycles in half a conversion clock period
  function [5:0] half_cycles;
    input [2:0] f;
    begin
      case (f)
        3'b000:  half_cycles = 6'd1;
        3'b100:  half_cycles = 6'd2;
        3'b001:  half_cycles = 6'd4;
        3'b101:  half_cycles = 6'd8;
        3'b010:  half_cycles = 6'd16;
        3'b110:  half_cycles = 6'd32;
        default: half_cycles = 6'd0;
      endcase
    end
  endfunction

  wire use_rc = (clk_field_in[1:0] == 2'b11);

  always @(posedge clk_in) begin
    if (reset_in || !run_in) begin
      cnt_r         <= 6'd0;
      half_tick_out <= 1'b0;
    end else if (use_rc) begin
      cnt_r         <= 6'd0;
      half_tick_out <= rc_tick_in;
    end else if (cnt_r + 6'd1 >= half_cycles(clk_field_in)) begin
      cnt_r         <= 6'd0;
      half_tick_out <= 1'b1;
    end else begin
      cnt_r         <= cnt_r + 6'd1;
      half_tick_out <= 1'b0;
    end
  end
endmodule
